// [hdl/tecs_axis_det.sv]
/*
 * single and double tap detector for one axis.
 * assumes magnitude and threshold share the fixed 0.063 g code, one step per sample.
 */
`timescale 1ns/1ns

module tecs_axis_det
    import tecs_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // bank side
    tecs_axis_if.det axis_io
);

    // ------------------------------------------------------------------
    // detector state
    // ------------------------------------------------------------------
    tecs_state_type state;
    logic [7:0] cnt;
    logic sign_hold;
    logic above;

    assign above = axis_io.magnitude > axis_io.threshold;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= TECS_IDLE;
            cnt <= 8'h00;
            sign_hold <= 1'b0;
        end
        else if (axis_io.sample_valid)
        begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            unique case (state)
                TECS_IDLE:
                begin
                    if (above)
                    begin
                        state <= TECS_FIRST;
                        cnt <= 8'h00;
                        sign_hold <= axis_io.sign;
                    end
                end
                TECS_FIRST:
                begin
                    if (!above)
                    begin
                        state <= TECS_LATENCY;
                        cnt <= 8'h00;
                    end
                    else if (cnt >= axis_io.time_limit)
                    begin
                        state <= TECS_WAIT_LOW;
                    end
                end
                TECS_LATENCY:
                begin
                    if (cnt >= axis_io.latency)
                    begin
                        state <= TECS_WINDOW;
                        cnt <= 8'h00;
                    end
                    else if (above && axis_io.abort)
                    begin
                        state <= TECS_LAT_PULSE;
                    end
                    // without abort a pulse here is ignored
                end
                TECS_LAT_PULSE:
                begin
                    if (!above)
                    begin
                        state <= TECS_IDLE;
                    end
                    else if (cnt >= axis_io.latency)
                    begin
                        state <= TECS_WINDOW;
                        cnt <= 8'h00;
                    end
                end
                TECS_WINDOW:
                begin
                    if (above)
                    begin
                        state <= TECS_SECOND;
                        cnt <= 8'h00;
                        sign_hold <= axis_io.sign;
                    end
                    else if (cnt >= axis_io.window)
                    begin
                        state <= TECS_IDLE;
                    end
                end
                TECS_SECOND:
                begin
                    if (!above)
                    begin
                        state <= TECS_IDLE;
                    end
                    else if (cnt >= axis_io.time_limit)
                    begin
                        state <= TECS_WAIT_LOW;
                    end
                end
                TECS_WAIT_LOW:
                begin
                    if (!above)
                    begin
                        state <= TECS_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // event pulses, one clock each, and the held sign of the last tap
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            axis_io.single_evt <= 1'b0;
            axis_io.double_evt <= 1'b0;
            axis_io.evt_sign <= 1'b0;
        end
        else
        begin
            axis_io.single_evt <= axis_io.sample_valid && !above && state == TECS_FIRST;
            axis_io.double_evt <= axis_io.sample_valid && !above && state == TECS_SECOND;
            axis_io.evt_sign <= sign_hold;
        end
    end

endmodule : tecs_axis_det

// [hdl/tecs_axis_if.sv]
/*
 * carrier between the register bank and one per-axis tap detector.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns

interface tecs_axis_if;
    logic sample_valid;
    logic [6:0] magnitude;
    logic sign;
    logic [6:0] threshold;
    logic [7:0] time_limit;
    logic [7:0] latency;
    logic [7:0] window;
    logic abort;
    logic single_evt;
    logic double_evt;
    logic evt_sign;

    modport det
    (
        input sample_valid,
        input magnitude,
        input sign,
        input threshold,
        input time_limit,
        input latency,
        input window,
        input abort,
        output single_evt,
        output double_evt,
        output evt_sign
    );

    modport ctl
    (
        output sample_valid,
        output magnitude,
        output sign,
        output threshold,
        output time_limit,
        output latency,
        output window,
        output abort,
        input single_evt,
        input double_evt,
        input evt_sign
    );
endinterface : tecs_axis_if

// [hdl/tecs_bank.sv]
/*
 * tap event configuration, threshold and source registers with three axis detectors.
 * assumes the serial interface outside decodes accesses into one-cycle read and write
 * strobes, and that signed 8-bit samples arrive at 0.063 g per code with a valid strobe.
 */
`timescale 1ns/1ns

module tecs_bank
    import tecs_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register access from the serial interface
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // acceleration samples, one step per output data sample
    input wire logic sample_valid_in,
    input wire logic [7:0] sample_x_in,
    input wire logic [7:0] sample_y_in,
    input wire logic [7:0] sample_z_in,
    // settings held outside this bank
    input wire logic low_noise_in,
    input wire logic [7:0] time_limit_in,
    input wire logic [7:0] latency_in,
    input wire logic [7:0] window_in,
    // status
    output logic tap_irq_out,
    output logic [7:0] tap_source_out
);
    import tecs_pkg::*;

    // ------------------------------------------------------------------
    // field position tables, indexed x, y, z
    // ------------------------------------------------------------------
    localparam int unsigned SINGLE_EN_POS [AXES] =
        '{X_SINGLE_TAP_ENABLE_BIT, Y_SINGLE_TAP_ENABLE_BIT, Z_SINGLE_TAP_ENABLE_BIT};
    localparam int unsigned DOUBLE_EN_POS [AXES] =
        '{X_DOUBLE_TAP_ENABLE_BIT, Y_DOUBLE_TAP_ENABLE_BIT, Z_DOUBLE_TAP_ENABLE_BIT};
    localparam int unsigned EVENT_POS [AXES] =
        '{X_TAP_EVENT_BIT, Y_TAP_EVENT_BIT, Z_TAP_EVENT_BIT};
    localparam int unsigned SIGN_POS [AXES] =
        '{X_TAP_SIGN_BIT, Y_TAP_SIGN_BIT, Z_TAP_SIGN_BIT};

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] tap_config;
    logic [7:0] tap_source;
    logic [6:0] tap_threshold [AXES];
    logic [7:0] sample [AXES];
    logic [AXES-1:0] single_hit;
    logic [AXES-1:0] double_hit;
    logic [AXES-1:0] hit_sign;
    logic any_hit;
    logic source_read;
    logic frozen;
    logic [7:0] next_source_event;
    logic [7:0] next_tap_source;
    logic [7:0] next_rdata;

    assign sample[0] = sample_x_in;
    assign sample[1] = sample_y_in;
    assign sample[2] = sample_z_in;
    assign source_read = reg_rd_in && reg_addr_in == TAP_SOURCE_ADDR;

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tap_config <= TAP_CONFIG_RESET;
        end
        else if (reg_wr_in && reg_addr_in == TAP_CONFIG_ADDR)
        begin
            tap_config <= reg_wdata_in;
        end
    end

    // ------------------------------------------------------------------
    // per-axis thresholds and detectors
    // ------------------------------------------------------------------
    for (genvar a = 0; a < AXES; a++)
    begin : g_axis
        tecs_axis_if axis_link ();
        logic [6:0] magnitude;
        logic [7:0] neg;

        always_ff @(posedge clk_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                tap_threshold[a] <= TAP_THRESHOLD_RESET;
            end
            else if (reg_wr_in && reg_addr_in == TAP_THRESHOLD_X_ADDR + 8'(a))
            begin
                tap_threshold[a] <= reg_wdata_in[6:0];
            end
        end

        // -128 has no 7-bit magnitude, so it saturates to full scale
        assign neg = 8'h00 - sample[a];
        assign magnitude = !sample[a][7] ? sample[a][6:0] :
                           neg[7] ? MAGNITUDE_MAX : neg[6:0];

        assign axis_link.sample_valid = sample_valid_in;
        assign axis_link.magnitude = magnitude;
        assign axis_link.sign = sample[a][7];
        // low noise keeps the detector below 4 g whatever is programmed
        assign axis_link.threshold = (low_noise_in && tap_threshold[a] > LOW_NOISE_MAX_CODE) ?
                                     LOW_NOISE_MAX_CODE : tap_threshold[a];
        assign axis_link.time_limit = time_limit_in;
        assign axis_link.latency = latency_in;
        assign axis_link.window = window_in;
        assign axis_link.abort = tap_config[DOUBLE_TAP_ABORT_BIT];

        tecs_axis_det u_det
        (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .axis_io(axis_link.det)
        );

        assign single_hit[a] = axis_link.single_evt && tap_config[SINGLE_EN_POS[a]];
        assign double_hit[a] = axis_link.double_evt && tap_config[DOUBLE_EN_POS[a]];
        assign hit_sign[a] = axis_link.evt_sign;
    end

    assign any_hit = |(single_hit | double_hit);
    assign frozen = tap_source[EVENT_ACTIVE_BIT] && tap_config[FLAG_LATCH_ENABLE_BIT];

    // ------------------------------------------------------------------
    // source register update
    // ------------------------------------------------------------------
    always_comb
    begin
        next_source_event = TAP_SOURCE_RESET;
        next_source_event[EVENT_ACTIVE_BIT] = 1'b1;
        next_source_event[DOUBLE_TAP_FLAG_BIT] = |double_hit;
        for (int a = 0; a < AXES; a++)
        begin
            next_source_event[EVENT_POS[a]] = single_hit[a] | double_hit[a];
            next_source_event[SIGN_POS[a]] =
                (single_hit[a] | double_hit[a]) & hit_sign[a];
        end
    end

    always_comb
    begin
        next_tap_source = tap_source;
        if (any_hit)
        begin
            // an event in the read cycle wins over the clear so it is not lost
            if (source_read || !frozen)
            begin
                next_tap_source = next_source_event;
            end
        end
        else if (source_read)
        begin
            next_tap_source = TAP_SOURCE_RESET;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tap_source <= TAP_SOURCE_RESET;
            tap_irq_out <= 1'b0;
            tap_source_out <= TAP_SOURCE_RESET;
        end
        else
        begin
            tap_source <= next_tap_source;
            tap_irq_out <= next_tap_source[EVENT_ACTIVE_BIT];
            tap_source_out <= next_tap_source;
        end
    end

    // ------------------------------------------------------------------
    // read data, captured before the clear takes effect
    // ------------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr_in)
            TAP_CONFIG_ADDR: next_rdata = tap_config;
            TAP_SOURCE_ADDR: next_rdata = tap_source;
            TAP_THRESHOLD_X_ADDR: next_rdata = {1'b0, tap_threshold[0]};
            TAP_THRESHOLD_Y_ADDR: next_rdata = {1'b0, tap_threshold[1]};
            TAP_THRESHOLD_Z_ADDR: next_rdata = {1'b0, tap_threshold[2]};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= next_rdata;
        end
    end

endmodule : tecs_bank

// [hdl/tecs_pkg.sv]
/*
 * constants, field layouts and types for the tap event configuration and status block.
 * assumes one 25 MHz clock and 8-bit registers at byte offsets 0x21 to 0x25.
 */
package tecs_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TAP_CONFIG_ADDR = 8'h21;
    localparam logic [7:0] TAP_SOURCE_ADDR = 8'h22;
    localparam logic [7:0] TAP_THRESHOLD_X_ADDR = 8'h23;
    localparam logic [7:0] TAP_THRESHOLD_Y_ADDR = 8'h24;
    localparam logic [7:0] TAP_THRESHOLD_Z_ADDR = 8'h25;

    // ------------------------------------------------------------------
    // tap_config fields
    // ------------------------------------------------------------------
    localparam int unsigned DOUBLE_TAP_ABORT_BIT = 7;
    localparam int unsigned FLAG_LATCH_ENABLE_BIT = 6;
    localparam int unsigned Z_DOUBLE_TAP_ENABLE_BIT = 5;
    localparam int unsigned Z_SINGLE_TAP_ENABLE_BIT = 4;
    localparam int unsigned Y_DOUBLE_TAP_ENABLE_BIT = 3;
    localparam int unsigned Y_SINGLE_TAP_ENABLE_BIT = 2;
    localparam int unsigned X_DOUBLE_TAP_ENABLE_BIT = 1;
    localparam int unsigned X_SINGLE_TAP_ENABLE_BIT = 0;

    // ------------------------------------------------------------------
    // tap_source fields
    // ------------------------------------------------------------------
    localparam int unsigned EVENT_ACTIVE_BIT = 7;
    localparam int unsigned Z_TAP_EVENT_BIT = 6;
    localparam int unsigned Y_TAP_EVENT_BIT = 5;
    localparam int unsigned X_TAP_EVENT_BIT = 4;
    localparam int unsigned DOUBLE_TAP_FLAG_BIT = 3;
    localparam int unsigned Z_TAP_SIGN_BIT = 2;
    localparam int unsigned Y_TAP_SIGN_BIT = 1;
    localparam int unsigned X_TAP_SIGN_BIT = 0;

    // ------------------------------------------------------------------
    // widths, reset values, limits
    // ------------------------------------------------------------------
    localparam int unsigned AXES = 3;
    localparam int unsigned THRESHOLD_W = 7;
    localparam logic [7:0] TAP_CONFIG_RESET = 8'h00;
    localparam logic [7:0] TAP_SOURCE_RESET = 8'h00;
    localparam logic [6:0] TAP_THRESHOLD_RESET = 7'h00;
    // 4 g at 0.063 g per code, fixed 8 g scale
    localparam logic [6:0] LOW_NOISE_MAX_CODE = 7'h3f;
    localparam logic [6:0] MAGNITUDE_MAX = 7'h7f;

    // ------------------------------------------------------------------
    // per-axis detector states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        TECS_IDLE,
        TECS_FIRST,
        TECS_LATENCY,
        TECS_LAT_PULSE,
        TECS_WINDOW,
        TECS_SECOND,
        TECS_WAIT_LOW
    } tecs_state_type;

endpackage : tecs_pkg

// [testbench/tecs_bank_chk.sv]
/*
 * concurrent checks on the ports of the tap event register bank.
 * assumes one clock domain and this checker bound into the bank by module name below.
 */
`timescale 1ns/1ns

module tecs_bank_chk
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register access
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    // samples and status
    input wire logic sample_valid_in,
    input wire logic tap_irq_out,
    input wire logic [7:0] tap_source_out
);
    import tecs_pkg::*;

    logic [7:0] cfg_shadow;
    logic src_rd;

    assign src_rd = reg_rd_in && (reg_addr_in == TAP_SOURCE_ADDR);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // latch mode is not visible at the ports, so track config writes
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cfg_shadow <= TAP_CONFIG_RESET;
        else if (reg_wr_in && (reg_addr_in == TAP_CONFIG_ADDR))
            cfg_shadow <= reg_wdata_in;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_cfg_wr;
        reg_wr_in && (reg_addr_in == TAP_CONFIG_ADDR);
    endsequence
    sequence s_cfg_rd;
        reg_rd_in && !reg_wr_in && (reg_addr_in == TAP_CONFIG_ADDR);
    endsequence

    AST_IRQ_MIRROR: assert property (tap_irq_out == tap_source_out[EVENT_ACTIVE_BIT])
        else $error("irq differs from event active bit");
    AST_EA_HOLD: assert property (
        tap_source_out[EVENT_ACTIVE_BIT] && !src_rd |=> tap_source_out[EVENT_ACTIVE_BIT])
        else $error("event active dropped without a read");
    AST_READ_CLEAR: assert property (
        src_rd && !$past(sample_valid_in) |=> tap_source_out == 8'h00 && !tap_irq_out)
        else $error("source read did not clear status");
    AST_READ_DATA: assert property (src_rd |=> reg_rdata_out == $past(tap_source_out))
        else $error("source read returned wrong value");
    AST_RESET_ZERO: assert property (
        $rose(rst_n_in) |-> tap_source_out == TAP_SOURCE_RESET && reg_rdata_out == 8'h00)
        else $error("outputs not zero after reset");
    AST_SRC_CAUSE: assert property (
        $changed(tap_source_out) && tap_source_out != 8'h00 |-> $past(sample_valid_in, 2))
        else $error("source changed without a sample");
    AST_UNMAPPED: assert property (reg_rd_in && (reg_addr_in < TAP_CONFIG_ADDR ||
        reg_addr_in > TAP_THRESHOLD_Z_ADDR) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_THR_TOP_ZERO: assert property (reg_rd_in && reg_addr_in >= TAP_THRESHOLD_X_ADDR &&
        reg_addr_in <= TAP_THRESHOLD_Z_ADDR |=> !reg_rdata_out[7])
        else $error("threshold bit 7 not zero");
    AST_CFG_READBACK: assert property (
        s_cfg_wr ##1 s_cfg_rd |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("config readback mismatch");
    AST_LATCH_FREEZE: assert property (cfg_shadow[FLAG_LATCH_ENABLE_BIT] &&
        tap_source_out[EVENT_ACTIVE_BIT] && !src_rd |=> $stable(tap_source_out))
        else $error("latched status changed");
endmodule : tecs_bank_chk

bind tecs_bank tecs_bank_chk u_chk
(
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
    .tap_irq_out(tap_irq_out), .tap_source_out(tap_source_out)
);

// [testbench/tecs_bank_tb.sv]
/*
 * self-checking bench for the tap event register bank.
 * assumes the checker is bound in and the host model drives the strobes.
 */
`timescale 1ns/1ns

module tecs_bank_tb;
    import tecs_pkg::*;

    logic clk_in, rst_n, sample_valid, low_noise, reg_wr, reg_rd, tap_irq, rd_seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sx, sy, sz, tlim, lat, win, tap_src;
    logic [7:0] exp_q [$];
    logic [7:0] dpat [9] = '{8'h0a, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00};
    logic [31:0] seed, r;
    int n_mismatch, check_count, i, a;

    tecs_host_model u_host (.clk_in(clk_in), .addr_out(reg_addr), .wr_out(reg_wr),
        .rd_out(reg_rd), .wdata_out(reg_wdata));
    tecs_bank uut (.clk_in(clk_in), .rst_n_in(rst_n), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .sample_valid_in(sample_valid), .sample_x_in(sx),
        .sample_y_in(sy), .sample_z_in(sz), .low_noise_in(low_noise), .time_limit_in(tlim),
        .latency_in(lat), .window_in(win), .tap_irq_out(tap_irq), .tap_source_out(tap_src));

    always #20 clk_in = ~clk_in;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] e);
        check_count++;
        if (seen !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, e, seen);
        end
    endtask : check

    task automatic summarize();
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(ad);
    endtask : rdc

    task automatic setcfg(input logic [7:0] v);
        u_host.wr(TAP_CONFIG_ADDR, v);
        rdc(TAP_CONFIG_ADDR, v);
        u_host.idle();
    endtask : setcfg

    task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        sample_valid <= 1'b1;
        sx <= x;
        sy <= y;
        sz <= z;
        @(posedge clk_in);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : smp

    // trailing quiet samples let the detector fall back to idle
    task automatic tap(input int ax, input logic [7:0] v);
        logic [7:0] s [3];
        s = '{default: 8'h00};
        s[ax] = v;
        smp(s[0], s[1], s[2]);
        repeat (11) smp(8'h00, 8'h00, 8'h00);
    endtask : tap

    function automatic logic [7:0] exp_src(input int ax, input logic dbl, input logic neg);
        exp_src = 8'h80 | (8'h10 << ax) | {4'h0, dbl, 3'h0} | ({7'h00, neg} << ax);
    endfunction : exp_src

    // ------------------------------------------------------------------
    // read data monitor
    // ------------------------------------------------------------------
    always @(posedge clk_in)
    begin
        if (rd_seen)
            check("read data", reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end

    initial
    begin
        repeat (100000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        clk_in = 1'b0;
        rst_n = 1'b0;
        rd_seen = 1'b0;
        sample_valid = 1'b0;
        {sx, sy, sz, low_noise} = '0;
        tlim = 8'h03;
        lat = 8'h02;
        win = 8'h04;
        seed = 32'h1345;
        repeat (20) @(posedge clk_in);
        rst_n <= 1'b1;
        @(posedge clk_in);
        for (i = 0; i < 5; i++)
            rdc(TAP_CONFIG_ADDR + 8'(i), 8'h00);
        rdc(8'h30, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            r = $random(seed);
            u_host.wr(TAP_THRESHOLD_X_ADDR + 8'(i), r[7:0]);
            rdc(TAP_THRESHOLD_X_ADDR + 8'(i), {1'b0, r[6:0]});
        end
        u_host.wr(TAP_SOURCE_ADDR, 8'hff);
        rdc(TAP_SOURCE_ADDR, 8'h00);
        for (i = 0; i < 3; i++)
            u_host.wr(TAP_THRESHOLD_X_ADDR + 8'(i), 8'h05);
        u_host.idle();
        for (a = 0; a < 3; a++)
        begin
            setcfg(8'h40 | (8'h01 << (2 * a)));
            tap(a, 8'hf6);
            check("irq", {7'h00, tap_irq}, 8'h01);
            check("source", tap_src, exp_src(a, 1'b0, 1'b1));
            rdc(TAP_SOURCE_ADDR, exp_src(a, 1'b0, 1'b1));
            u_host.idle();
            @(posedge clk_in);
            check("irq", {7'h00, tap_irq}, 8'h00);
            setcfg(8'h40 | (8'h02 << (2 * a)));
            tap(a, 8'h0a);
            rdc(TAP_SOURCE_ADDR, 8'h00);
            setcfg(8'h40 | (8'h01 << (2 * ((a + 1) % 3))));
            tap(a, 8'h0a);
            rdc(TAP_SOURCE_ADDR, 8'h00);
        end
        setcfg(8'h41);
        tap(0, 8'h05);
        rdc(TAP_SOURCE_ADDR, 8'h00);
        setcfg(8'h45);
        tap(0, 8'h0a);
        tap(1, 8'hf6);
        rdc(TAP_SOURCE_ADDR, 8'h90);
        setcfg(8'h05);
        tap(0, 8'h0a);
        tap(1, 8'hf6);
        rdc(TAP_SOURCE_ADDR, 8'ha2);
        setcfg(8'h41);
        u_host.wr(TAP_THRESHOLD_X_ADDR, 8'h7f);
        u_host.idle();
        tap(0, 8'h50);
        rdc(TAP_SOURCE_ADDR, 8'h00);
        u_host.idle();
        low_noise <= 1'b1;
        tap(0, 8'h50);
        rdc(TAP_SOURCE_ADDR, 8'h90);
        low_noise <= 1'b0;
        u_host.wr(TAP_THRESHOLD_X_ADDR, 8'h05);
        lat <= 8'h04;
        win <= 8'h06;
        for (a = 0; a < 2; a++)
        begin
            setcfg(a == 0 ? 8'h42 : 8'hc2);
            for (i = 0; i < 9; i++)
                smp(dpat[i], 8'h00, 8'h00);
            tap(0, 8'h00);
            rdc(TAP_SOURCE_ADDR, a == 0 ? exp_src(0, 1'b1, 1'b0) : 8'h00);
        end
        u_host.idle();
        for (i = 0; i < 20 && exp_q.size() > 0; i++)
            @(posedge clk_in);
        if (exp_q.size() > 0)
            n_mismatch++;
        summarize();
    end
endmodule : tecs_bank_tb

// [testbench/tecs_host_model.sv]
/*
 * host model issuing register strobes to the bank that stay up until the next task.
 * assumes each task is entered just after a rising edge.
 */
`timescale 1ns/1ns

module tecs_host_model
(
    // clock
    input wire logic clk_in,
    // register strobes
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out
);
    initial
    begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    // strobes stay up between tasks so back-to-back access needs no gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        rd_out <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        addr_out <= a;
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        @(posedge clk_in);
    endtask : rd

    // released bus shows the inverse, never a stale copy
    task automatic idle();
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        addr_out <= ~addr_out;
        wdata_out <= ~wdata_out;
        @(posedge clk_in);
    endtask : idle
endmodule : tecs_host_model
